/* File: migt_pkg.sv */
// Purpose: constants for the inter-packet gap timing block
// Assumes: 32-bit register port, 50 MHz system clock
// Notes: one gap register plus set, clear and invert companions
package migt_pkg;
  // register offsets (byte addresses)
  localparam logic [7:0] GAP_REG_OFS = 8'h00;
  localparam logic [7:0] GAP_CLR_OFS = 8'h04;
  localparam logic [7:0] GAP_SET_OFS = 8'h08;
  localparam logic [7:0] GAP_INV_OFS = 8'h0c;
  localparam logic [7:0] GAP_STAT_OFS = 8'h10;
  // field positions
  localparam int GAP1_LSB = 8;
  localparam int GAP2_LSB = 0;
  localparam int GAP_W = 7;
  // reset values
  localparam logic [6:0] GAP1_RST = 7'h0c;
  localparam logic [6:0] GAP2_RST = 7'h12;
  // access size codes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  // gap timer state
  typedef enum logic [1:0] {
    MIGT_BUSY,
    MIGT_PART1,
    MIGT_PART2,
    MIGT_READY
  } migt_state_type;
endpackage : migt_pkg

/* File: migt_regs.sv */
// Purpose: gap configuration register with set, clear and invert aliases
// Assumes: one-cycle write strobe with an access size code
// Notes: byte writes are dropped; unimplemented bits never store
`timescale 1ns/10ps
module migt_regs (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // write side
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [31:0] wr_data,
  input wire logic [1:0] wr_size,
  // fields
  output logic [6:0] carrier_sense_window,
  output logic [6:0] nonb2b_gap_total
);
  import migt_pkg::*;
  logic [31:0] cur_val;
  logic [31:0] nxt_val;
  logic [31:0] wmask;
  logic [6:0] cw_ff;
  logic [6:0] gt_ff;
  logic size_ok;
  assign cur_val = {17'h0_0000, cw_ff, 1'b0, gt_ff};
  assign size_ok = (wr_size == SZ_HALF) || (wr_size == SZ_WORD); // RL5 RL6
  // halfword writes reach only the low lanes, which hold every field
  assign wmask = (wr_size == SZ_WORD) ? 32'hffff_ffff : 32'h0000_ffff;
  always_comb begin
    unique case (wr_addr)
      GAP_CLR_OFS: nxt_val = cur_val & ~(wr_data & wmask);
      GAP_SET_OFS: nxt_val = cur_val | (wr_data & wmask);
      GAP_INV_OFS: nxt_val = cur_val ^ (wr_data & wmask);
      default: nxt_val = (cur_val & ~wmask) | (wr_data & wmask);
    endcase
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cw_ff <= GAP1_RST;
      gt_ff <= GAP2_RST;
    end else if (wr_en && size_ok) begin
      cw_ff <= nxt_val[GAP1_LSB +: GAP_W]; // RL7
      gt_ff <= nxt_val[GAP2_LSB +: GAP_W];
    end
  end
  assign carrier_sense_window = cw_ff;
  assign nonb2b_gap_total = gt_ff;
  a_byte_ignored: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr_en && wr_size == SZ_BYTE) |=> $stable(cw_ff) && $stable(gt_ff))
    else $error("byte write changed gap fields"); // RL6
endmodule : migt_regs

/* File: migt_timer.sv */
// Purpose: two-part inter-packet gap timer
// Assumes: gap counted in clock cycles of the transmit rate
// Notes: both parts timed from the same idle instant
`timescale 1ns/10ps
module migt_timer (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // medium and config
  input wire logic medium_busy,
  input wire logic carrier_sense,
  input wire logic [6:0] carrier_sense_window,
  input wire logic [6:0] nonb2b_gap_total,
  // status
  output migt_pkg::migt_state_type state,
  output logic [6:0] gap_count,
  output logic deferred
);
  import migt_pkg::*;
  migt_state_type state_ff;
  logic [6:0] cnt_ff;
  logic defer_ff;
  logic in_part1;
  assign in_part1 = cnt_ff < carrier_sense_window;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= MIGT_BUSY;
      cnt_ff <= 7'h00;
    end else if (medium_busy) begin
      state_ff <= MIGT_BUSY;
      cnt_ff <= 7'h00;
    end else begin
      unique case (state_ff)
        MIGT_BUSY: begin
          state_ff <= MIGT_PART1; // RL8
          cnt_ff <= 7'h00;
        end
        MIGT_PART1: begin
          if (carrier_sense && in_part1) begin
            state_ff <= MIGT_BUSY; // RL1
            cnt_ff <= 7'h00;
          end else if (cnt_ff + 7'h01 >= nonb2b_gap_total) begin
            state_ff <= MIGT_READY;
          end else begin
            cnt_ff <= cnt_ff + 7'h01;
            if (!in_part1) state_ff <= MIGT_PART2;
          end
        end
        MIGT_PART2: begin
          // carrier ignored here: transmit anyway for fair access
          if (cnt_ff + 7'h01 >= nonb2b_gap_total) state_ff <= MIGT_READY; // RL2
          else cnt_ff <= cnt_ff + 7'h01; // RL8
        end
        MIGT_READY: state_ff <= MIGT_READY;
      endcase
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) defer_ff <= 1'b0;
    else if (!medium_busy && state_ff == MIGT_PART1 && carrier_sense && in_part1)
      defer_ff <= 1'b1;
    else if (state_ff == MIGT_READY) defer_ff <= 1'b0;
  end
  assign state = state_ff;
  assign gap_count = cnt_ff;
  assign deferred = defer_ff;
  a_window_defer: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_ff == MIGT_PART1 && !medium_busy && carrier_sense && in_part1)
    |=> state_ff == MIGT_BUSY) else $error("no defer in window"); // RL1
  a_late_carrier: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_ff == MIGT_PART2 && !medium_busy && carrier_sense)
    |=> state_ff != MIGT_BUSY) else $error("late carrier caused defer"); // RL2
  a_defer_flag: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL1
    (state_ff == MIGT_PART1 && !medium_busy && carrier_sense && in_part1)
    |=> defer_ff) else $error("deferral not flagged");
endmodule : migt_timer

/* File: migt_top.sv */
// Purpose: transmit deferral and non-back-to-back gap timing of a MAC
// Assumes: synchronous medium inputs, plain register port
// Notes: read data appears the cycle after the read strobe
// Summary of operation
// RL1 - carrier seen during part one window makes the MAC defer
// RL2 - carrier after part one: keep timing part two, then transmit anyway
// RL3 - software keeps part one between zero and part two, typically twelve
// RL4 - bits 6..0 hold total gap, eighteen gives the minimum gap
// RL5 - halfword and word accesses work on the register and its aliases
// RL6 - byte accesses are ignored, stored values unchanged
// RL7 - bits 31..15 and bit 7 read zero, writes ignored
// RL8 - both parts timed from the idle instant, part two total
`timescale 1ns/10ps
module migt_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [1:0] reg_size,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // medium
  input wire logic medium_busy,
  input wire logic carrier_sense,
  input wire logic tx_pending,
  // transmit control
  output logic tx_start,
  output logic tx_deferred
);
  import migt_pkg::*;
  logic [6:0] carrier_sense_window;
  logic [6:0] nonb2b_gap_total;
  migt_state_type gstate;
  logic [6:0] gap_count;
  logic deferred;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic start_ff;
  logic defer_ff;
  logic rd_ok;

  migt_regs u_regs (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .wr_en(reg_wr),
    .wr_addr(reg_addr),
    .wr_data(reg_wdata),
    .wr_size(reg_size),
    .carrier_sense_window(carrier_sense_window),
    .nonb2b_gap_total(nonb2b_gap_total)
  );

  migt_timer u_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .medium_busy(medium_busy),
    .carrier_sense(carrier_sense),
    .carrier_sense_window(carrier_sense_window),
    .nonb2b_gap_total(nonb2b_gap_total), // RL4
    .state(gstate),
    .gap_count(gap_count),
    .deferred(deferred)
  );

  assign rd_ok = (reg_size == SZ_HALF) || (reg_size == SZ_WORD); // RL5 RL6
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (reg_rd && rd_ok) begin
      unique case (reg_addr)
        GAP_REG_OFS, GAP_CLR_OFS, GAP_SET_OFS, GAP_INV_OFS:
          nxt_rdata = {17'h0_0000, carrier_sense_window, 1'b0, nonb2b_gap_total}; // RL7
        GAP_STAT_OFS:
          nxt_rdata = {21'h00_0000, deferred, gstate, 1'b0, gap_count};
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
    if (reg_size == SZ_HALF) nxt_rdata[31:16] = 16'h0000;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) rdata_ff <= 32'h0000_0000;
    else rdata_ff <= nxt_rdata;
  end

  // start pulses every other cycle while the gap has expired, the medium is idle and a frame is pending
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) start_ff <= 1'b0;
    else start_ff <= tx_pending && !medium_busy && !start_ff && gstate == MIGT_READY; // RL2
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) defer_ff <= 1'b0;
    else defer_ff <= deferred; // RL1
  end

  assign reg_rdata = rdata_ff;
  assign tx_start = start_ff;
  assign tx_deferred = defer_ff;

  a_rsvd_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_rd |=> reg_rdata[7] == 1'b0 && reg_rdata[31:15] == 17'h0_0000 ||
      $past(reg_addr) == GAP_STAT_OFS) else $error("reserved bits nonzero"); // RL7
  a_no_early_tx: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tx_start |-> $past(gstate) == MIGT_READY) else $error("tx before gap"); // RL8
endmodule : migt_top

/* File: migt_phy.sv */
// Purpose: medium side model, busy period then idle with optional carrier
// Assumes: one go pulse per frame, carrier delay counted in idle cycles
// Notes: carrier is a one-cycle burst; 0 means none
`timescale 1ns/10ps
module migt_phy (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // command
  input wire logic go,
  input wire logic [7:0] car_dly,
  // medium
  output logic medium_busy,
  output logic carrier_sense
);
  logic [7:0] k_ff;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) k_ff <= 8'h00;
    else if (go) k_ff <= 8'h01;
    else if (k_ff != 8'h00 && k_ff < 8'h3c) k_ff <= k_ff + 8'h01;
  end
  assign medium_busy = k_ff inside {[8'h01:8'h03]};
  // carrier appears car_dly cycles into the idle gap
  assign carrier_sense = car_dly != 8'h00 && k_ff == car_dly + 8'h03;
endmodule : migt_phy

/* File: tb.sv */
// Purpose: self-checking bench for the gap register and gap timer
// Assumes: register port with one-cycle strobes, phy model on the medium
// Notes: random register traffic from a fixed seed plus timing corners
`timescale 1ns/10ps
module tb;
  import migt_pkg::*;
  logic sys_clk, rst_n, reg_wr, reg_rd, tx_pending, go, tx_start, tx_deferred;
  logic medium_busy, carrier_sense, seen_def;
  logic [7:0] reg_addr, car_dly, a;
  logic [31:0] reg_wdata, reg_rdata, shadow, rv, d;
  logic [1:0] reg_size, s;
  integer mismatches = 0, n_checks = 0, seed = 84202, i, t;
  migt_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_size(reg_size), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .medium_busy(medium_busy), .carrier_sense(carrier_sense), .tx_pending(tx_pending),
    .tx_start(tx_start), .tx_deferred(tx_deferred));
  migt_phy phy (.sys_clk(sys_clk), .rst_n(rst_n), .go(go), .car_dly(car_dly),
    .medium_busy(medium_busy), .carrier_sense(carrier_sense));
  initial begin
    sys_clk = 0;
    forever #10 sys_clk = ~sys_clk;
  end
  task check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task results;
    if (mismatches == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  function automatic logic [31:0] apply(logic [31:0] sh, logic [7:0] ad, logic [31:0] dv,
                                        logic [1:0] sz);
    logic [31:0] d2;
    d2 = (sz == SZ_HALF) ? (dv & 32'h0000_ffff) : dv;
    if (sz != SZ_HALF && sz != SZ_WORD) return sh;
    case (ad)
      GAP_CLR_OFS: d2 = sh & ~d2;
      GAP_SET_OFS: d2 = sh | d2;
      GAP_INV_OFS: d2 = sh ^ d2;
      default: ;
    endcase
    return d2 & 32'h0000_7f7f;
  endfunction : apply
  task wr(input logic [7:0] ad, input logic [31:0] dv, input logic [1:0] sz);
    reg_addr <= ad;
    reg_wdata <= dv;
    reg_size <= sz;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  task rd(input logic [7:0] ad, input logic [1:0] sz);
    reg_addr <= ad;
    reg_size <= sz;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
    @(posedge sys_clk);
  endtask : rd
  // one frame on the medium; t counts cycles until transmit may start
  // carrier needs car_dly >= 2 to land while part one is being timed
  task gap(input logic [7:0] cd, input logic exp_def, input integer lo, input integer hi);
    car_dly <= cd;
    go <= 1'b1;
    seen_def = 1'b0;
    @(posedge sys_clk);
    go <= 1'b0;
    for (t = 1; t < 60; t++) begin
      @(posedge sys_clk);
      #1 seen_def = seen_def | tx_deferred;
      if (tx_start === 1'b1) break;
    end
    check("deferred", 32'(seen_def), 32'(exp_def));
    check("gap_len", 32'(t - 3 >= lo && t - 3 <= hi), 1);
    repeat (3) @(posedge sys_clk);
  endtask : gap
  initial begin
    #200000;
    mismatches++;
    results();
  end
  initial begin
    {rst_n, reg_wr, reg_rd, tx_pending, go} = 0;
    {reg_addr, reg_wdata, reg_size, car_dly} = 0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    shadow = 32'h0000_0c12;
    rd(GAP_REG_OFS, SZ_WORD);
    check("gap_reset", rv, shadow);
    for (i = 0; i < 40; i++) begin
      a = 8'(({$random(seed)} % 4) * 4);
      d = $random(seed);
      s = 2'($random(seed));
      wr(a, d, s);
      shadow = apply(shadow, a, d, s);
      rd(8'(({$random(seed)} % 4) * 4), (i % 2) ? SZ_HALF : SZ_WORD);
      check("gap_reg", rv, shadow);
      rd(a, SZ_BYTE);
      check("byte_rd", rv, 0);
    end
    rd(8'h20, SZ_WORD);
    check("unmapped", rv, 0);
    wr(GAP_REG_OFS, 32'hffff_8208, SZ_WORD);
    tx_pending <= 1'b1;
    gap(8'h00, 1'b0, 8, 12);
    gap(8'h02, 1'b1, 9, 20);
    gap(8'h05, 1'b0, 8, 12);
    rd(GAP_STAT_OFS, SZ_WORD);
    check("status", rv, 32'h0000_0307);
    results();
  end
endmodule : tb
